// ### bkrg_top.v
// Buck regulator mode control: SPI registers, three rails, faults
//
// What this block does
// - State field bits 2:0 codes 4..7 select off, PFM, pulse skip, PWM; 0..3 are reserved.
// - DDR rail control register is at 0x37, read/write, reset 0x04.
// - First pre-regulator control register is at 0x38, read/write, reset 0x07.
// - Operating mode is selectable by host writes over SPI.
// - DDR rail over-current limits each cycle and raises its fault and the shared fault.
// - First pre-regulator over-current limits each cycle and raises its fault and the shared fault.
// - Second pre-regulator over-current limits each cycle and raises its fault and the shared fault.
// - Each rail's output discharge is enabled whenever the rail is shut down.
// - Each rail's ADC output current is held in a host readable register.
// - All three rails switch at 4.0 MHz.
// - Second pre-regulator register at 0x39 resets 0x07 with voltage select in bits 7:6.
`timescale 1ns/10ps
`include "bkrg_consts.vh"
module bkrg_top #(
   parameter ADC_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire spi_sclk_i,
   input wire spi_cs_n_i,
   input wire spi_mosi_i,
   output reg spi_miso_o,
   output reg spi_miso_oe_o,
   input wire standby_exit_pin_i,
   input wire [2:0] oc_i,
   input wire [3*ADC_W-1:0] adc_current_i,
   input wire [2:0] adc_valid_i,
   output wire [2:0] ddr_buck_state_o,
   output wire [2:0] prereg_a_state_o,
   output wire [2:0] prereg_b_state_o,
   output wire [1:0] prereg_b_voltage_select_o,
   output wire [2:0] discharge_o,
   output wire [2:0] gate_o,
   output wire ddr_buck_fault_o,
   output wire prereg_a_fault_o,
   output wire prereg_b_fault_o,
   output wire regulator_fault_irq_o
);
   localparam [31:0] SW_DIV = `BKRG_SYS_HZ / `BKRG_SW_HZ;
   localparam [31:0] SW_LAST_W = SW_DIV - 1;
   localparam [31:0] SW_HALF_W = SW_DIV / 2;
   localparam [3:0] SW_LAST = SW_LAST_W[3:0];
   localparam [3:0] SW_HALF = SW_HALF_W[3:0];

   reg [2:0] sclk_sync_reg;
   reg [1:0] cs_sync_reg;
   reg [1:0] mosi_sync_reg;
   reg [2:0] exit_sync_reg;
   reg wr_stb_reg;
   wire [7:0] rd_data;
   reg [2:0] oc_s1_reg;
   reg [2:0] oc_s2_reg;
   reg [3:0] sw_cnt_reg;
   reg [3:0] bit_cnt_reg;
   reg [15:0] shift_reg;
   reg [7:0] tx_reg;
   reg hdr_done_reg;
   reg [2:0] fault_reg;
   reg [2:0] fault_next;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_act;
   wire exit_rise;
   wire frame_wr;
   wire [6:0] frame_addr;
   wire [7:0] frame_data;
   wire sw_start;
   wire sw_half;
   wire [2:0] oc_event;
   wire [7:0] ctrl_ddr;
   wire [7:0] ctrl_pra;
   wire [7:0] ctrl_prb;
   wire [ADC_W-1:0] cur0;
   wire [ADC_W-1:0] cur1;
   wire [ADC_W-1:0] cur2;
   wire [2:0] wr_sel;

   // Pin synchronisers, first stage read only by second
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sclk_sync_reg <= 3'h0;
         cs_sync_reg <= 2'h3;
         mosi_sync_reg <= 2'h0;
         exit_sync_reg <= 3'h0;
         oc_s1_reg <= 3'h0;
         oc_s2_reg <= 3'h0;
      end
      else
      begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
         cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_i};
         mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
         exit_sync_reg <= {exit_sync_reg[1:0], standby_exit_pin_i};
         oc_s1_reg <= oc_i;
         oc_s2_reg <= oc_s1_reg;
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign cs_act = ~cs_sync_reg[1];
   assign exit_rise = exit_sync_reg[1] & ~exit_sync_reg[2];

   // Shared 4 MHz switching phase from the 20 MHz clock
   always @(posedge clk_i)
   begin
      if (rst_i || sw_cnt_reg == SW_LAST)
         sw_cnt_reg <= 4'h0;
      else
         sw_cnt_reg <= sw_cnt_reg + 4'h1;
   end
   assign sw_start = (sw_cnt_reg == 4'h0);
   assign sw_half = (sw_cnt_reg == SW_HALF);

   // Register read decode
   function [7:0] rd_mux;
      input [6:0] a;
      begin
         case (a)
            `BKRG_ADDR_DDR: rd_mux = ctrl_ddr;
            `BKRG_ADDR_PRA: rd_mux = ctrl_pra;
            `BKRG_ADDR_PRB: rd_mux = ctrl_prb;
            `BKRG_ADDR_CUR0_LO: rd_mux = cur0[7:0];
            `BKRG_ADDR_CUR0_HI: rd_mux = {6'h00, cur0[ADC_W-1:8]};
            `BKRG_ADDR_CUR1_LO: rd_mux = cur1[7:0];
            `BKRG_ADDR_CUR1_HI: rd_mux = {6'h00, cur1[ADC_W-1:8]};
            `BKRG_ADDR_CUR2_LO: rd_mux = cur2[7:0];
            `BKRG_ADDR_CUR2_HI: rd_mux = {6'h00, cur2[ADC_W-1:8]};
            `BKRG_ADDR_FAULT: rd_mux = {5'h00, fault_reg};
            default: rd_mux = 8'h00;
         endcase
      end
   endfunction

   // Read data for the address held after the header
   assign rd_data = rd_mux(shift_reg[`BKRG_HA_MSB:`BKRG_HA_LSB]);

   // SPI frame: rw bit, 7 address bits, 8 data bits, MSB first
   always @(posedge clk_i)
   begin
      if (rst_i || !cs_act)
      begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 16'h0000;
         tx_reg <= 8'h00;
         hdr_done_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end
      else
      begin
         wr_stb_reg <= 1'b0;
         if (sclk_rise)
         begin
            shift_reg <= {shift_reg[14:0], mosi_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `BKRG_SPI_HDR_LAST)
               hdr_done_reg <= 1'b1;
            // Last bit of a write frame: commit on the next cycle
            if (bit_cnt_reg == `BKRG_SPI_LAST)
               wr_stb_reg <= shift_reg[`BKRG_RW_BIT];
         end
         if (sclk_fall && hdr_done_reg)
         begin
            spi_miso_oe_o <= 1'b1;
            if (bit_cnt_reg == `BKRG_SPI_DATA_FIRST)
            begin
               spi_miso_o <= rd_data[7];
               tx_reg <= {rd_data[6:0], 1'b0};
            end
            else
            begin
               spi_miso_o <= tx_reg[7];
               tx_reg <= {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   // Write strobe and register select
   assign frame_wr = wr_stb_reg;
   assign frame_addr = shift_reg[`BKRG_FA_MSB:`BKRG_FA_LSB];
   assign frame_data = shift_reg[`BKRG_FD_MSB:`BKRG_FD_LSB];
   assign wr_sel[0] = frame_wr && (frame_addr == `BKRG_ADDR_DDR);
   assign wr_sel[1] = frame_wr && (frame_addr == `BKRG_ADDR_PRA);
   assign wr_sel[2] = frame_wr && (frame_addr == `BKRG_ADDR_PRB);

   // DDR rail, bits 7:6 fixed at zero
   bkrg_rail #(
      .RST_VAL(`BKRG_RST_DDR),
      .WR_MASK(8'h3F),
      .ADC_W(ADC_W)
   ) ddr_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sel[0]),
      .wdata_i(frame_data),
      .exit_i(exit_rise),
      .sw_start_i(sw_start),
      .sw_half_i(sw_half),
      .oc_i(oc_s2_reg[0]),
      .adc_i(adc_current_i[ADC_W-1:0]),
      .adc_valid_i(adc_valid_i[0]),
      .ctrl_o(ctrl_ddr),
      .state_o(ddr_buck_state_o),
      .discharge_o(discharge_o[0]),
      .gate_o(gate_o[0]),
      .oc_event_o(oc_event[0]),
      .current_o(cur0)
   );

   // First pre-regulator, bits 7:6 fixed at zero
   bkrg_rail #(
      .RST_VAL(`BKRG_RST_PRA),
      .WR_MASK(8'h3F),
      .ADC_W(ADC_W)
   ) pra_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sel[1]),
      .wdata_i(frame_data),
      .exit_i(exit_rise),
      .sw_start_i(sw_start),
      .sw_half_i(sw_half),
      .oc_i(oc_s2_reg[1]),
      .adc_i(adc_current_i[2*ADC_W-1:ADC_W]),
      .adc_valid_i(adc_valid_i[1]),
      .ctrl_o(ctrl_pra),
      .state_o(prereg_a_state_o),
      .discharge_o(discharge_o[1]),
      .gate_o(gate_o[1]),
      .oc_event_o(oc_event[1]),
      .current_o(cur1)
   );

   // Second pre-regulator with voltage select in bits 7:6
   bkrg_rail #(
      .RST_VAL(`BKRG_RST_PRB),
      .WR_MASK(8'hFF),
      .ADC_W(ADC_W)
   ) prb_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sel[2]),
      .wdata_i(frame_data),
      .exit_i(exit_rise),
      .sw_start_i(sw_start),
      .sw_half_i(sw_half),
      .oc_i(oc_s2_reg[2]),
      .adc_i(adc_current_i[3*ADC_W-1:2*ADC_W]),
      .adc_valid_i(adc_valid_i[2]),
      .ctrl_o(ctrl_prb),
      .state_o(prereg_b_state_o),
      .discharge_o(discharge_o[2]),
      .gate_o(gate_o[2]),
      .oc_event_o(oc_event[2]),
      .current_o(cur2)
   );
   assign prereg_b_voltage_select_o = ctrl_prb[`BKRG_VS_MSB:`BKRG_VS_LSB];

   // Per-rail fault follows over-current on a running rail
   always @*
   begin
      fault_next = oc_event;
   end

   // Fault flags
   always @(posedge clk_i)
   begin
      if (rst_i)
         fault_reg <= 3'h0;
      else
         fault_reg <= fault_next;
   end
   assign ddr_buck_fault_o = fault_reg[0];
   assign prereg_a_fault_o = fault_reg[1];
   assign prereg_b_fault_o = fault_reg[2];
   assign regulator_fault_irq_o = |fault_reg;
endmodule

// ### bkrg_consts.vh
// Constants for the buck regulator mode control block
`ifndef BKRG_CONSTS_VH
`define BKRG_CONSTS_VH
`define BKRG_ADDR_DDR 7'h37
`define BKRG_ADDR_PRA 7'h38
`define BKRG_ADDR_PRB 7'h39
`define BKRG_ADDR_CUR0_LO 7'h70
`define BKRG_ADDR_CUR0_HI 7'h71
`define BKRG_ADDR_CUR1_LO 7'h72
`define BKRG_ADDR_CUR1_HI 7'h73
`define BKRG_ADDR_CUR2_LO 7'h74
`define BKRG_ADDR_CUR2_HI 7'h75
`define BKRG_ADDR_FAULT 7'h7F
`define BKRG_RST_DDR 8'h04
`define BKRG_RST_PRA 8'h07
`define BKRG_RST_PRB 8'h07
`define BKRG_ST_MSB 2
`define BKRG_ST_LSB 0
`define BKRG_EX_MSB 5
`define BKRG_EX_LSB 3
`define BKRG_VS_MSB 7
`define BKRG_VS_LSB 6
`define BKRG_CODE_VALID 2
`define BKRG_ST_OFF 3'h4
`define BKRG_ST_PFM 3'h5
`define BKRG_ST_APS 3'h6
`define BKRG_ST_PWM 3'h7
`define BKRG_SYS_HZ 20000000
`define BKRG_SW_HZ 4000000
`define BKRG_SPI_BITS 16
`define BKRG_SPI_HDR_LAST 4'h7
`define BKRG_SPI_LAST 4'hF
`define BKRG_RW_BIT 14
`define BKRG_SPI_DATA_FIRST 4'h8
`define BKRG_HA_MSB 6
`define BKRG_HA_LSB 0
`define BKRG_FA_MSB 14
`define BKRG_FA_LSB 8
`define BKRG_FD_MSB 7
`define BKRG_FD_LSB 0
`endif

// ### bkrg_rail.v
// One buck rail: mode register, exit copy, discharge, current limit
`timescale 1ns/10ps
`include "bkrg_consts.vh"
module bkrg_rail #(
   parameter [7:0] RST_VAL = 8'h04,
   parameter [7:0] WR_MASK = 8'h3F,
   parameter ADC_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire exit_i,
   input wire sw_start_i,
   input wire sw_half_i,
   input wire oc_i,
   input wire [ADC_W-1:0] adc_i,
   input wire adc_valid_i,
   output wire [7:0] ctrl_o,
   output wire [2:0] state_o,
   output reg discharge_o,
   output reg gate_o,
   output wire oc_event_o,
   output reg [ADC_W-1:0] current_o
);
   reg [7:0] ctrl_reg;
   reg [7:0] ctrl_next;
   wire [2:0] exit_code;
   wire [2:0] wr_state;
   wire running;

   assign exit_code = ctrl_reg[`BKRG_EX_MSB:`BKRG_EX_LSB];
   assign wr_state = wdata_i[`BKRG_ST_MSB:`BKRG_ST_LSB];
   assign ctrl_o = ctrl_reg;
   assign state_o = ctrl_reg[`BKRG_ST_MSB:`BKRG_ST_LSB];
   assign running = (state_o != `BKRG_ST_OFF);
   assign oc_event_o = oc_i & running;

   // Next control value: host write, then exit copy on top
   always @*
   begin
      ctrl_next = ctrl_reg;
      if (wr_i)
      begin
         ctrl_next = (wdata_i & WR_MASK) | (ctrl_reg & ~WR_MASK);
         if (!wr_state[`BKRG_CODE_VALID])
            ctrl_next[`BKRG_ST_MSB:`BKRG_ST_LSB] = state_o;
      end
      if (exit_i && exit_code[`BKRG_CODE_VALID])
         ctrl_next[`BKRG_ST_MSB:`BKRG_ST_LSB] = exit_code;
   end

   // Control register
   always @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_reg <= RST_VAL;
      else
         ctrl_reg <= ctrl_next;
   end

   // Discharge while off, gate pulse with cycle-by-cycle limit
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         discharge_o <= 1'b0;
         gate_o <= 1'b0;
      end
      else
      begin
         discharge_o <= ~running;
         if (!running || oc_i || sw_half_i)
            gate_o <= 1'b0;
         else if (sw_start_i)
            gate_o <= 1'b1;
      end
   end

   // Latest converted output current
   always @(posedge clk_i)
   begin
      if (rst_i)
         current_o <= {ADC_W{1'b0}};
      else if (adc_valid_i)
         current_o <= adc_i;
   end
endmodule

// ### bkrg_top_chk.sv
// Checker bound to the buck regulator mode control top
`timescale 1ns/10ps
module bkrg_top_chk (
   input wire clk_i,
   input wire rst_i,
   input wire spi_cs_n_i,
   input wire standby_exit_pin_i,
   input wire [2:0] oc_i,
   input wire [2:0] ddr_buck_state_o,
   input wire [2:0] prereg_a_state_o,
   input wire [2:0] prereg_b_state_o,
   input wire [2:0] discharge_o,
   input wire [2:0] gate_o,
   input wire ddr_buck_fault_o,
   input wire prereg_a_fault_o,
   input wire prereg_b_fault_o,
   input wire regulator_fault_irq_o
);
   reg [3:0] quiet;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since the last host frame or exit pin activity
   always @(posedge clk_i)
      if (rst_i || !spi_cs_n_i || standby_exit_pin_i)
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   property p_rst; $past(rst_i) |-> {ddr_buck_state_o, prereg_a_state_o,
      prereg_b_state_o} == 9'h13F; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_code; ddr_buck_state_o[2] && prereg_a_state_o[2] &&
      prereg_b_state_o[2]; endproperty
   a_code: assert property (p_code) else $error("reserved state");
   property p_f0; (oc_i[0] && ddr_buck_state_o != 3'h4) [*3] |=>
      ddr_buck_fault_o; endproperty
   a_f0: assert property (p_f0) else $error("fault 0");
   property p_f1; (oc_i[1] && prereg_a_state_o != 3'h4) [*3] |=>
      prereg_a_fault_o; endproperty
   a_f1: assert property (p_f1) else $error("fault 1");
   property p_f2; (oc_i[2] && prereg_b_state_o != 3'h4) [*3] |=>
      prereg_b_fault_o; endproperty
   a_f2: assert property (p_f2) else $error("fault 2");
   property p_irq; (ddr_buck_fault_o || prereg_a_fault_o ||
      prereg_b_fault_o) |-> ##[0:2] regulator_fault_irq_o; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_dis; $rose(ddr_buck_state_o == 3'h4) |-> ##[0:3]
      discharge_o[0]; endproperty
   a_dis: assert property (p_dis) else $error("discharge");
   property p_hold; quiet == 4'hF |-> $stable(ddr_buck_state_o); endproperty
   a_hold: assert property (p_hold) else $error("state moved");
   property p_gate; ddr_buck_state_o == 3'h4 |=> !gate_o[0]; endproperty
   a_gate: assert property (p_gate) else $error("gate while off");
   c_exit: cover property ($rose(standby_exit_pin_i));
   c_irq: cover property (regulator_fault_irq_o);
   c_dis: cover property (discharge_o[0]);
endmodule
bind bkrg_top bkrg_top_chk chk_u (.*);

// ### bkrg_spi_host.sv
// Host model driving frames on the register serial port
`timescale 1ns/10ps
module bkrg_spi_host (
   input wire clk_i,
   input wire miso_i,
   output reg sclk_o,
   output reg cs_n_o,
   output reg mosi_o
);
   reg [15:0] sh;
   integer i;
   initial {sclk_o, cs_n_o, mosi_o} = 3'b010;
   // One frame, first bit high for write, data sampled while clock high
   task xfer(input wr, input [6:0] a, input [7:0] d, output [7:0] q);
      begin
         sh = {wr, a, d};
         q = 8'h00;
         @(posedge clk_i) cs_n_o <= 1'b0;
         for (i = 15; i >= 0; i = i - 1)
         begin
            mosi_o <= sh[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (i < 8)
               q[i] = miso_i;
            sclk_o <= 1'b0;
         end
         repeat (4) @(posedge clk_i);
         cs_n_o <= 1'b1;
         mosi_o <= ~mosi_o;
         repeat (8) @(posedge clk_i);
      end
   endtask
endmodule

// ### bkrg_top_bench.sv
// Self-checking bench for the buck regulator mode control top
`timescale 1ns/10ps
module bkrg_top_bench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg exit_r = 1'b0;
   reg [2:0] oc_r = 3'h0;
   reg [2:0] av_r = 3'h0;
   reg [29:0] adc_r = 30'h0;
   reg [7:0] q;
   wire sclk, cs_n, mosi, miso, oe, f0, f1, f2, irq;
   wire [2:0] st0, st1, st2;
   wire [1:0] vs;
   wire miso_w = oe ? miso : ~miso;
   integer error_cnt = 0;
   integer checks = 0;
   integer k;
   bkrg_spi_host host_u (.clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk),
      .cs_n_o(cs_n), .mosi_o(mosi));
   bkrg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
      .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_o(oe), .standby_exit_pin_i(exit_r), .oc_i(oc_r),
      .adc_current_i(adc_r), .adc_valid_i(av_r), .ddr_buck_state_o(st0),
      .prereg_a_state_o(st1), .prereg_b_state_o(st2),
      .prereg_b_voltage_select_o(vs), .discharge_o(), .gate_o(),
      .ddr_buck_fault_o(f0), .prereg_a_fault_o(f1),
      .prereg_b_fault_o(f2), .regulator_fault_irq_o(irq));
   // Compare and count
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("Error %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   task rd(input [6:0] a, input [7:0] e);
      begin
         host_u.xfer(1'b0, a, 8'h00, q);
         chk(q, e);
      end
   endtask
   task wrap_up;
      begin
         if (error_cnt == 0 && checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial forever #25 clk_i = ~clk_i;
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(7'h37, 8'h04);
      rd(7'h38, 8'h07);
      rd(7'h39, 8'h07);
      for (k = 4; k < 8; k = k + 1)
      begin
         wr(7'h38, k[7:0]);
         chk({5'h0, st1}, k[7:0]);
      end
      wr(7'h37, 8'hFF);
      rd(7'h37, 8'h3F);
      wr(7'h39, 8'h46);
      chk({6'h0, vs}, 8'h01);
      wr(7'h37, 8'h2C);
      @(posedge clk_i) exit_r <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({st0, st2, 2'h0}, 8'hB8);
      wr(7'h37, 8'h2C);
      chk({5'h0, st0}, 8'h04);
      wr(7'h37, 8'h07);
      exit_r <= 1'b0;
      oc_r <= 3'h7;
      repeat (4) @(posedge clk_i);
      chk({4'h0, f0, f1, f2, irq}, 8'h0F);
      oc_r <= 3'h0;
      adc_r <= 30'h2A5;
      av_r <= 3'h1;
      @(posedge clk_i) av_r <= 3'h0;
      rd(7'h70, 8'hA5);
      rd(7'h71, 8'h02);
      wrap_up;
   end
   // Watchdog against a hung frame
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt = error_cnt + 1;
      wrap_up;
   end
endmodule
